// file: hdl/direct_bank_address_mapper.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "direct_bank_map.svh"
// Notes on behaviour
// RQ1 - One 64 Kbyte space split into I/O, extended I/O, data, program.
// RQ2 - 0x0000-0x007F is I/O, reachable normally and by direct operands.
// RQ3 - 0x0F80-0x0FFF is extended I/O, reachable by normal access only.
// RQ4 - RAM fills data area; 0x0090-0x00FF reachable by direct operands.
// RQ5 - Banked direct reach ends at 0x047F large, 0x028F small RAM.
// RQ6 - 0x0100-0x01FF is general register area and still plain RAM.
// RQ7 - 0xFFC0-0xFFFF is the vector table area of flash.
// RQ8 - 0xFFBB-0xFFBF holds the stored non-volatile register data.
// RQ9 - Direct operands 0x00-0x7F map unchanged whatever the bank pointer.
// RQ10 - Bank pointer resets to 0; then operands 0x90-0xFF map unchanged.
// RQ11 - Pointer 1..7 maps operands 0x80-0xFF to 128-byte windows from 0x100.
// RQ12 - Window parts beyond implemented RAM are flagged invalid.
// RQ13 - After power-on the shared pin is reset input and reset output.
// RQ14 - Reset output enable bit gates driving internal reset onto the pin.
// RQ15 - Pin function select bit picks reset input or general purpose I/O.
// RQ16 - In debug mode the debug pin is the debug tool link.
// RQ17 - Debug tool keeps debug pin released until reset output releases.
// RQ18 - Stabilization wait follows power-on and wake, even on external clock.
// RQ19 - Pointer 0 with operands 0x80-0x8F is unmapped, without side effect.
module direct_bank_address_mapper #(
	parameter logic [15:0] RAM_LAST = `MEM_RAM_LAST_LARGE,
	parameter int STAB_CYCLES = `STAB_CYCLES
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	// CPU access
	input direct_bank_pkg::cpu_req_s cpu_req_in,
	output logic [15:0] phys_addr_out,
	output direct_bank_pkg::region_s region_out,
	output logic map_valid_out,
	// Reset sources and shared reset pin
	input wire logic sys_reset_req_in,
	input wire logic port_f_bit2_pin_in,
	output logic port_f_bit2_pin_out,
	output logic port_f_bit2_pin_oe_out,
	output logic ext_reset_req_out,
	output logic gpio_in_out,
	// Debug link
	input wire logic debug_mode_in,
	input wire logic debug_tx_low_in,
	input wire logic debug_comm_pin_in,
	output logic debug_comm_pin_out,
	output logic debug_comm_pin_oe_out,
	output logic debug_rx_out,
	// Clock stabilization
	input wire logic wake_in,
	output logic clock_stable_out
);
	import direct_bank_pkg::*;

	logic [7:0] system_config_register_r;
	logic [2:0] direct_bank_pointer_r;
	logic [7:0] reg_rdata_r;
	logic [15:0] phys_addr_r;
	region_s region_r;
	logic map_valid_r;
	stab_state_e stab_state_r;
	stab_state_e stab_state_nxt;
	logic [31:0] stab_count_r;
	logic [31:0] stab_count_nxt;

	// Register decode
	wire sel_cfg = reg_addr_in == `REG_SYS_CONFIG;
	wire sel_bank = reg_addr_in == `REG_BANK_PTR;
	wire sel_status = reg_addr_in == `REG_STATUS;
	wire [7:0] status_word = {5'h00, debug_comm_pin_in,
		port_f_bit2_pin_in, clock_stable_out};
	logic [7:0] rd_word;
	always_comb begin
		if (sel_cfg) begin
			rd_word = system_config_register_r;
		end else if (sel_bank) begin
			rd_word = {5'h00, direct_bank_pointer_r};
		end else if (sel_status) begin
			rd_word = status_word;
		end else begin
			rd_word = 8'h00;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			system_config_register_r <= `CFG_RESET; // see RQ13
			direct_bank_pointer_r <= `BANK_PTR_RESET; // see RQ10
			reg_rdata_r <= 8'h00;
		end else begin
			if (reg_write_in && sel_cfg) begin
				system_config_register_r <= {4'h0, reg_wdata_in[3:0]};
			end
			if (reg_write_in && sel_bank) begin
				direct_bank_pointer_r <= reg_wdata_in[2:0];
			end
			if (reg_read_in) begin
				reg_rdata_r <= rd_word;
			end
		end
	end
	assign reg_rdata_out = reg_rdata_r;

	// Direct operand translation
	wire [7:0] operand = cpu_req_in.addr[7:0];
	wire op_fixed = operand <= `DIR_FIXED_LAST; // see RQ9
	wire bank_zero = direct_bank_pointer_r == 3'h0;
	wire op_hole = bank_zero && !op_fixed &&
		operand <= `DIR_HOLE_LAST; // see RQ19
	// Pointer n lands operand 0x80 at (n+1)*0x80, so the sum is the address
	wire [15:0] banked = {6'h00, direct_bank_pointer_r, 7'h00} +
		{8'h00, operand}; // see RQ11
	wire [15:0] direct_phys = (op_fixed || bank_zero) ?
		{8'h00, operand} : banked; // see RQ10
	wire [15:0] phys = cpu_req_in.direct ? direct_phys : cpu_req_in.addr;

	// Region decode over the whole 64 Kbyte space
	wire in_io = phys <= `MEM_IO_LAST; // see RQ2
	wire in_ext = phys >= `MEM_EXT_IO_FIRST &&
		phys <= `MEM_EXT_IO_LAST; // see RQ3
	wire in_ram = phys >= `MEM_RAM_FIRST &&
		phys <= RAM_LAST; // see RQ4 RQ5
	wire in_gpr = phys >= `MEM_GPR_FIRST &&
		phys <= `MEM_GPR_LAST; // see RQ6
	wire in_nv_data = phys >= `MEM_NV_DATA_FIRST &&
		phys <= `MEM_NV_DATA_LAST; // see RQ8
	wire in_vec = phys >= `MEM_VECTOR_FIRST; // see RQ7
	wire in_prog = phys >= `MEM_FLASH_FIRST; // see RQ1
	// Banked windows past the last RAM byte are refused
	wire dir_bad = cpu_req_in.direct && (op_hole ||
		(!op_fixed && !in_ram)); // see RQ12
	wire any_hit = in_io || in_ext || in_ram || in_prog;
	wire unmapped = dir_bad || !any_hit;
	region_s region;
	assign region = '{
		io: in_io && !dir_bad,
		ext_io: in_ext && !cpu_req_in.direct,
		ram: in_ram && !dir_bad,
		gpr: in_gpr && !dir_bad, // see RQ6
		flash: in_prog && !cpu_req_in.direct,
		nv_data: in_nv_data && !cpu_req_in.direct,
		vector: in_vec && !cpu_req_in.direct,
		unmapped: unmapped
	};

	// Unmapped answers carry no select so nothing is touched
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			phys_addr_r <= 16'h0000;
			region_r <= '0;
			map_valid_r <= 1'b0;
		end else begin
			map_valid_r <= cpu_req_in.valid;
			if (cpu_req_in.valid) begin
				phys_addr_r <= phys;
				region_r <= region; // see RQ19
			end
		end
	end
	assign phys_addr_out = phys_addr_r;
	assign region_out = region_r;
	assign map_valid_out = map_valid_r;

	// Shared reset pin, open drain in reset mode
	wire pin_reset_mode = system_config_register_r[`CFG_PIN_FUNC_SEL];
	wire int_reset = rst_in || sys_reset_req_in;
	wire drive_reset = pin_reset_mode && int_reset &&
		system_config_register_r[`CFG_RESET_OUT_EN]; // see RQ14
	wire drive_gpio = !pin_reset_mode &&
		system_config_register_r[`CFG_GPIO_OUT_EN]; // see RQ15
	assign port_f_bit2_pin_oe_out = drive_reset || drive_gpio;
	assign port_f_bit2_pin_out = drive_gpio &&
		system_config_register_r[`CFG_GPIO_DATA];
	assign ext_reset_req_out = pin_reset_mode &&
		!port_f_bit2_pin_in; // see RQ13
	assign gpio_in_out = port_f_bit2_pin_in;

	// Debug link only active in debug mode; the tool is trusted to
	// leave the line high until the reset output releases
	assign debug_comm_pin_oe_out = debug_mode_in &&
		debug_tx_low_in; // see RQ16
	assign debug_comm_pin_out = 1'b0;
	assign debug_rx_out = debug_mode_in ?
		debug_comm_pin_in : 1'b1; // see RQ16 RQ17

	// Stabilization wait is kept even with an external clock,
	// trading start-up time for one uniform path
	always_comb begin
		stab_state_nxt = stab_state_r;
		stab_count_nxt = stab_count_r;
		case (stab_state_r)
			STAB_WAITING: begin
				if (stab_count_r >= STAB_CYCLES - 1) begin
					stab_state_nxt = STAB_RUNNING;
					stab_count_nxt = 32'h0;
				end else begin
					stab_count_nxt = stab_count_r + 32'h1;
				end
			end
			STAB_RUNNING: begin
				stab_count_nxt = 32'h0;
			end
			default: begin
				stab_state_nxt = STAB_WAITING;
			end
		endcase
		if (wake_in) begin
			stab_state_nxt = STAB_WAITING; // see RQ18
			stab_count_nxt = 32'h0;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			stab_state_r <= STAB_WAITING; // see RQ18
			stab_count_r <= 32'h0;
		end else begin
			stab_state_r <= stab_state_nxt;
			stab_count_r <= stab_count_nxt;
		end
	end
	assign clock_stable_out = stab_state_r == STAB_RUNNING;

	// Checks
	sequence s_direct_req;
		cpu_req_in.valid && cpu_req_in.direct;
	endsequence
	sequence s_fixed_op;
		s_direct_req ##0 cpu_req_in.addr[7:0] <= 8'h7f;
	endsequence
	property p_fixed_map;
		@(posedge clock_in) disable iff (rst_in)
		s_fixed_op |=> phys_addr_out == {8'h00, $past(cpu_req_in.addr[7:0])}
			&& region_out.io && map_valid_out;
	endproperty
	a_fixed_map: assert property (p_fixed_map) // see RQ9
		else $error("Fixed direct operand moved");
	property p_bank_map;
		@(posedge clock_in) disable iff (rst_in)
		(s_direct_req ##0 cpu_req_in.addr[7] && direct_bank_pointer_r != 3'h0)
		|=> phys_addr_out == 16'h0080 * $past(direct_bank_pointer_r) +
			{8'h00, $past(cpu_req_in.addr[7:0])};
	endproperty
	a_bank_map: assert property (p_bank_map) // see RQ11
		else $error("Banked operand mapped wrongly");
	property p_bank_zero;
		@(posedge clock_in) disable iff (rst_in)
		(s_direct_req ##0 direct_bank_pointer_r == 3'h0 &&
			cpu_req_in.addr[7:0] >= 8'h90) |=> region_out.ram &&
			phys_addr_out[15:8] == 8'h00 && !region_out.unmapped;
	endproperty
	a_bank_zero: assert property (p_bank_zero) // see RQ10
		else $error("Bank zero operand not identity");
	property p_hole;
		@(posedge clock_in) disable iff (rst_in)
		(s_direct_req ##0 direct_bank_pointer_r == 3'h0 &&
			cpu_req_in.addr[7:4] == 4'h8) |=> region_out.unmapped &&
			!region_out.ram && !region_out.io;
	endproperty
	a_hole: assert property (p_hole) // see RQ19
		else $error("Direct hole not unmapped");
	property p_ram_limit;
		@(posedge clock_in) disable iff (rst_in)
		map_valid_out && region_out.ram |-> phys_addr_out <= RAM_LAST;
	endproperty
	a_ram_limit: assert property (p_ram_limit) // see RQ12
		else $error("RAM flagged past last byte");
	property p_ext_io;
		@(posedge clock_in) disable iff (rst_in)
		map_valid_out && region_out.ext_io |-> phys_addr_out[15:7] == 9'h01f
			&& !$past(cpu_req_in.direct);
	endproperty
	a_ext_io: assert property (p_ext_io) // see RQ3
		else $error("Extended I/O decode wrong");
	property p_vector;
		@(posedge clock_in) disable iff (rst_in)
		(cpu_req_in.valid && !cpu_req_in.direct &&
			cpu_req_in.addr[15:6] == 10'h3ff) |=> region_out.vector &&
			region_out.flash && !region_out.nv_data;
	endproperty
	a_vector: assert property (p_vector) // see RQ7
		else $error("Vector area not decoded");
	property p_reset_drive;
		@(posedge clock_in) disable iff (rst_in)
		sys_reset_req_in && system_config_register_r[1:0] == 2'h3 |->
			port_f_bit2_pin_oe_out && !port_f_bit2_pin_out;
	endproperty
	a_reset_drive: assert property (p_reset_drive) // see RQ14
		else $error("Reset not driven onto pin");
	property p_debug_idle;
		@(posedge clock_in) disable iff (rst_in)
		!debug_mode_in |-> !debug_comm_pin_oe_out;
	endproperty
	a_debug_idle: assert property (p_debug_idle) // see RQ16
		else $error("Debug pin driven outside debug");
	property p_stab_wake;
		@(posedge clock_in) disable iff (rst_in)
		wake_in |=> !clock_stable_out [*2];
	endproperty
	a_stab_wake: assert property (p_stab_wake) // see RQ18
		else $error("Wake skipped stabilization");
endmodule // direct_bank_address_mapper

// file: hdl/direct_bank_map.svh
`ifndef DIRECT_BANK_MAP_SVH
`define DIRECT_BANK_MAP_SVH
// Memory regions
`define MEM_IO_FIRST 16'h0000
`define MEM_IO_LAST 16'h007f
`define MEM_EXT_IO_FIRST 16'h0f80
`define MEM_EXT_IO_LAST 16'h0fff
`define MEM_RAM_FIRST 16'h0080
`define MEM_DIRECT_RAM_FIRST 16'h0090
`define MEM_RAM_LAST_LARGE 16'h047f
`define MEM_RAM_LAST_SMALL 16'h028f
`define MEM_GPR_FIRST 16'h0100
`define MEM_GPR_LAST 16'h01ff
`define MEM_FLASH_FIRST 16'hc000
`define MEM_NV_DATA_FIRST 16'hffbb
`define MEM_NV_DATA_LAST 16'hffbf
`define MEM_VECTOR_FIRST 16'hffc0
`define MEM_VECTOR_LAST 16'hffff
// Direct operand windows
`define DIR_FIXED_LAST 8'h7f
`define DIR_HOLE_LAST 8'h8f
`define BANK_PTR_RESET 3'h0
// Register offsets
`define REG_SYS_CONFIG 4'h0
`define REG_BANK_PTR 4'h1
`define REG_STATUS 4'h2
// System configuration fields and reset value
`define CFG_RESET_OUT_EN 0
`define CFG_PIN_FUNC_SEL 1
`define CFG_GPIO_DATA 2
`define CFG_GPIO_OUT_EN 3
`define CFG_RESET 8'h03
// Oscillation stabilization wait
`define STAB_WAIT_NS 40960
`define CLK_PERIOD_NS 10
`define STAB_CYCLES (`STAB_WAIT_NS / `CLK_PERIOD_NS)
`endif

// file: hdl/direct_bank_pkg.sv
package direct_bank_pkg;
	typedef struct packed {
		logic io;
		logic ext_io;
		logic ram;
		logic gpr;
		logic flash;
		logic nv_data;
		logic vector;
		logic unmapped;
	} region_s;
	typedef struct packed {
		logic valid;
		logic direct;
		logic [15:0] addr;
	} cpu_req_s;
	typedef enum logic {
		STAB_WAITING,
		STAB_RUNNING
	} stab_state_e;
endpackage

// file: tb/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
	// Clock
	input wire logic clock_in,
	// Request to mapper
	output direct_bank_pkg::cpu_req_s cpu_req_out
);
	import direct_bank_pkg::*;
	initial cpu_req_out = '0;
	// Idle lines show the inverse address so stale values never match
	task automatic issue(input logic dir, input logic [15:0] addr);
		@(posedge clock_in);
		cpu_req_out <= '{valid: 1'b1, direct: dir, addr: addr};
		@(posedge clock_in);
		cpu_req_out <= '{valid: 1'b0, direct: dir, addr: ~addr};
	endtask
endmodule // cpu_model

// file: tb/direct_bank_address_mapper_bench.sv
`timescale 1ns/1ps
`include "direct_bank_map.svh"
module direct_bank_address_mapper_bench;
	import direct_bank_pkg::*;
	logic clock_in = 0, rst_in = 1, wr = 0, rd = 0, sys_rst = 0, wake = 0;
	logic debug_mode = 0, debug_low = 0;
	logic [3:0] ra = '0;
	logic [7:0] wd = '0, rdat, r;
	cpu_req_s req;
	region_s reg_o, reg_s;
	logic [15:0] phys;
	logic mv, pf_o, pf_oe, ext_rst, gpio_i, debug_o, debug_oe, debug_rx;
	logic stable;
	wire pf_pin = pf_oe ? pf_o : 1'b1;
	wire debug_pin = debug_oe ? debug_o : 1'b1;
	int n_errors = 0, n_compared = 0;
	always #5 clock_in = ~clock_in;
	cpu_model u_cpu (.clock_in(clock_in), .cpu_req_out(req));
	direct_bank_address_mapper #(.STAB_CYCLES(8)) u_dut (
		.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(ra),
		.reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd),
		.reg_rdata_out(rdat), .cpu_req_in(req), .phys_addr_out(phys),
		.region_out(reg_o), .map_valid_out(mv), .sys_reset_req_in(sys_rst),
		.port_f_bit2_pin_in(pf_pin), .port_f_bit2_pin_out(pf_o),
		.port_f_bit2_pin_oe_out(pf_oe), .ext_reset_req_out(ext_rst),
		.gpio_in_out(gpio_i), .debug_mode_in(debug_mode),
		.debug_tx_low_in(debug_low), .debug_comm_pin_in(debug_pin),
		.debug_comm_pin_out(debug_o), .debug_comm_pin_oe_out(debug_oe),
		.debug_rx_out(debug_rx), .wake_in(wake), .clock_stable_out(stable));
	// Smallest RAM variant, so a bank window can run past the last byte
	direct_bank_address_mapper #(.RAM_LAST(`MEM_RAM_LAST_SMALL),
			.STAB_CYCLES(8)) u_small (
		.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(ra),
		.reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd),
		.reg_rdata_out(), .cpu_req_in(req), .phys_addr_out(),
		.region_out(reg_s), .map_valid_out(), .sys_reset_req_in(sys_rst),
		.port_f_bit2_pin_in(1'b1), .port_f_bit2_pin_out(),
		.port_f_bit2_pin_oe_out(), .ext_reset_req_out(),
		.gpio_in_out(), .debug_mode_in(1'b0),
		.debug_tx_low_in(1'b0), .debug_comm_pin_in(1'b1),
		.debug_comm_pin_out(), .debug_comm_pin_oe_out(),
		.debug_rx_out(), .wake_in(wake), .clock_stable_out());
	task automatic check(input logic [15:0] seen, exp, input string m);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s %h/%h", $time, m, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		ra <= a;
		wd <= d;
		wr <= 1;
		@(posedge clock_in);
		wr <= 0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock_in);
		ra <= a;
		rd <= 1;
		@(posedge clock_in);
		rd <= 0;
		#1 d = rdat;
	endtask
	// Issues one access and checks the translation and one region flag
	task automatic map(input logic dir, input logic [15:0] a, p,
			input int bit_i, input logic v);
		u_cpu.issue(dir, a);
		#1;
		check(mv, 1, "map valid");
		check(phys, p, "phys");
		check(reg_o[bit_i], v, "region flag");
	endtask
	task automatic t_stab();
		repeat (6) @(posedge clock_in);
		#1 check(stable, 0, "early stable");
		repeat (4) @(posedge clock_in);
		#1 check(stable, 1, "stable");
		@(posedge clock_in);
		wake <= 1;
		@(posedge clock_in);
		wake <= 0;
		#1 check(stable, 0, "wake restart");
		repeat (10) @(posedge clock_in);
		#1 check(stable, 1, "wake stable");
	endtask
	task automatic t_regs();
		reg_rd(`REG_SYS_CONFIG, r);
		check(r, `CFG_RESET, "config reset");
		reg_rd(`REG_BANK_PTR, r);
		check(r, `BANK_PTR_RESET, "bank reset");
		reg_rd(`REG_STATUS, r);
		check(r, 8'h07, "status");
		reg_wr(4'hf, 8'hff);
		reg_rd(4'hf, r);
		check(r, 0, "unmapped reg");
	endtask
	task automatic t_direct();
		for (int p = 0; p < 8; p++) begin
			reg_wr(`REG_BANK_PTR, p[7:0]);
			map(1, 16'h0020, 16'h0020, 7, 1);
			map(1, 16'h00ff, 16'(p * 128 + 255), 5, 1);
			map(1, 16'h0085, 16'(p * 128 + 133), 0, p == 0);
		end
		reg_wr(`REG_BANK_PTR, 8'h0);
		map(1, 16'h0090, 16'h0090, 5, 1);
		map(1, 16'h0090, 16'h0090, 4, 0);
		reg_wr(`REG_BANK_PTR, 8'h7);
		map(1, 16'h0080, 16'h0400, 6, 0);
		map(1, 16'h0080, 16'h0400, 5, 1);
		reg_wr(`REG_BANK_PTR, 8'h4);
		map(1, 16'h008f, 16'h028f, 5, 1);
		check(reg_s[5], 1, "small last byte");
		map(1, 16'h0090, 16'h0290, 5, 1);
		check({reg_s[5], reg_s[0]}, 2'b01, "small past end");
	endtask
	task automatic t_normal();
		logic [15:0] a [10] = '{16'h007f, 16'h0f80, 16'h0fff, 16'h0100,
			16'h01ff, 16'h047f, 16'hc000, 16'hffbb, 16'hffbf, 16'hffc0};
		int b [10] = '{7, 6, 6, 4, 4, 5, 3, 2, 2, 1};
		for (int i = 0; i < 10; i++)
			map(0, a[i], a[i], b[i], 1);
		map(0, 16'h0100, 16'h0100, 5, 1);
		map(0, 16'hffff, 16'hffff, 1, 1);
		map(0, 16'h0480, 16'h0480, 5, 0);
	endtask
	task automatic t_pins();
		@(posedge clock_in);
		sys_rst <= 1;
		#1 check({pf_oe, pf_o, ext_rst}, 3'b101, "reset out");
		reg_wr(`REG_SYS_CONFIG, 8'h02);
		#1 check(pf_oe, 0, "reset out off");
		sys_rst <= 0;
		reg_wr(`REG_SYS_CONFIG, 8'h0c);
		#1 check({pf_oe, pf_o, gpio_i}, 3'b111, "gpio out");
		reg_wr(`REG_SYS_CONFIG, 8'h08);
		#1 check({pf_oe, pf_o, ext_rst}, 3'b100, "gpio low");
		reg_wr(`REG_SYS_CONFIG, `CFG_RESET);
		debug_mode <= 1;
		debug_low <= 1;
		#1 check({debug_oe, debug_o, debug_rx}, 3'b100, "debug low");
		debug_low <= 0;
		#1 check({debug_oe, debug_rx}, 2'b01, "debug high");
		debug_mode <= 0;
	endtask
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		// Shared reset pin driven low through reset
		repeat (19) @(posedge clock_in);
		#1 check({pf_oe, pf_o}, 2'b10, "pin in reset");
		@(posedge clock_in);
		rst_in <= 0;
		t_stab();
		t_regs();
		t_direct();
		t_normal();
		t_pins();
		tally_and_finish();
	end
	initial begin
		#200us;
		n_errors++;
		tally_and_finish();
	end
endmodule // direct_bank_address_mapper_bench
